// ### rtl/fcfir_chain.sv
// Three-stage FIR chain with forward flow control, FIFO back pressure and output buffer.
`timescale 1ns/100ps
module fcfir_chain #(
    parameter fcfir_pkg::fcfir_arch_type            ARCH = fcfir_pkg::FCFIR_DIRECT,
    parameter logic [fcfir_pkg::NTAPS-1:0][fcfir_pkg::COEF_W-1:0] COEF = fcfir_pkg::COEF_DEF
) (
    input  wire logic                         clk,        // System clock, 100 MHz.
    input  wire logic                         reset_n,    // Asynchronous reset, active low.
    input  wire logic                         clk_en,     // Freezes all state while low.
    input  wire logic [fcfir_pkg::DATA_W-1:0] in_data,    // Source sample.
    input  wire logic                         in_valid,   // Source sample is valid.
    output logic                              in_ready,   // Chain accepts a sample.
    output logic [fcfir_pkg::DATA_W-1:0]      out_data,   // Filtered sample.
    output logic                              out_valid,  // Filtered sample is valid.
    input  wire logic                         out_ready   // Consumer takes the sample.
);

    // Short names for the package sizes used throughout.
    localparam int N  = fcfir_pkg::NTAPS;
    localparam int S  = fcfir_pkg::NSTAGES;
    localparam int DW = fcfir_pkg::DATA_W;
    localparam int AW = fcfir_pkg::FIFO_AW;
    localparam int FD = fcfir_pkg::FB_DELAY;

    // How the chain paces itself.
    // A stage takes a sample only when it is offered and its own ready is high,
    // so a low valid leaves the tap line and result data of that stage where they were.
    // The ready of a stage is the occupancy test of the FIFO right behind it,
    // passed through a short delay line, and it reaches back one stage only.
    // The delay stands for the stage latency, which keeps the loop easy to time
    // and lets stages be chained without any global control.
    // After the test trips, the delay plus one result register of samples can
    // still arrive, so the threshold sits well below the FIFO capacity.
    // The last FIFO empties into a two-entry buffer that holds the output port,
    // so every output comes from a register and a consumer stall loses no word.
    // The clock enable gates every register, the sample memories included,
    // so dropping it freezes the chain cycle for cycle.

    ////////////////////////////////////////////////////////////////////////////////
    // Signals joining the stages.
    // Vectors are indexed by stage, stage 0 nearest the source.
    logic [S-1:0]         src_valid;   // Sample offered to each stage.
    logic [S-1:0][DW-1:0] src_data;
    logic [S-1:0]         stage_rdy;   // Delayed ready into each stage.
    logic [S-1:0]         stage_take;  // Stage accepts a sample this cycle.
    logic [S-1:0]         fifo_valid;  // FIFO head is present.
    logic [S-1:0][DW-1:0] fifo_head;
    logic [S-1:0]         fifo_pop;
    logic                 buf_ready;   // Output buffer can take a word.

    // The first stage is fed by the source, every later one by the FIFO before it.
    // Each later stage thus reads the head of the FIFO that its predecessor fills.
    always_comb begin
        src_valid[0] = in_valid;
        src_data[0]  = in_data;
        for (int s = 1; s < S; s++) begin
            src_valid[s] = fifo_valid[s-1];
            src_data[s]  = fifo_head[s-1];
        end
    end

    // A stage takes a sample only when it is offered and its ready is high.
    // The pop of each FIFO is the take of what follows it, the next stage or the output buffer: valid and ready ANDed.
    always_comb begin
        for (int s = 0; s < S; s++) begin
            stage_take[s] = src_valid[s] & stage_rdy[s];
        end
        for (int s = 0; s < S - 1; s++) begin
            fifo_pop[s] = stage_take[s+1];
        end
        fifo_pop[S-1] = fifo_valid[S-1] & buf_ready;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stages: filter, FIFO and ready feedback.
    for (genvar s = 0; s < S; s++) begin : g_stage
        // Per-stage result register, ready delay line and FIFO state.
        fcfir_pkg::fcfir_beat_type res_d;
        fcfir_pkg::fcfir_beat_type res_q;
        logic [FD-1:0]             rdy_d;
        logic [FD-1:0]             rdy_q;
        logic [AW:0]               count_d;
        logic [AW:0]               count_q;
        logic [AW-1:0]             wptr_d;
        logic [AW-1:0]             wptr_q;
        logic [AW-1:0]             rptr_d;
        logic [AW-1:0]             rptr_q;
        logic [AW-1:0]             rd_addr;
        logic                      wr;
        logic                      en;

        // Stage enable is the take itself; the clock enable gates the registers.
        // A cycle without a take leaves the tap line and result data unchanged and clears the result valid flag.
        assign en = stage_take[s];

        if (ARCH == fcfir_pkg::FCFIR_DIRECT) begin : g_direct
            // Direct form: one register per tap after the first and one result register per stage.
            logic [N-2:0][DW-1:0]            taps_d;
            logic [N-2:0][DW-1:0]            taps_q;
            logic signed [fcfir_pkg::ACC_W-1:0] acc;

            // Sum of products runs every cycle; only the tap line and result are gated.
            // The tap line holds the three previous accepted samples, newest first,
            // so the history counts accepted samples only and gaps do not disturb it.
            // The result register takes the scaled sum and a valid flag on enable.
            always_comb begin
                acc = fcfir_pkg::fcfir_mac('0, src_data[s], COEF[0]);
                for (int k = 1; k < N; k++) begin
                    acc = fcfir_pkg::fcfir_mac(acc, taps_q[k-1], COEF[k]);
                end
                taps_d     = taps_q;
                res_d      = res_q;
                res_d.valid = 1'b0;
                if (en) begin
                    taps_d[0] = src_data[s];
                    for (int k = 1; k < N - 1; k++) begin
                        taps_d[k] = taps_q[k-1];
                    end
                    res_d.data  = fcfir_pkg::fcfir_scale(acc);
                    res_d.valid = 1'b1;
                end
            end

            // Tap line registers.
            // They clear to zero, so the first outputs see an empty history.
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    taps_q <= '0;
                end else if (clk_en) begin
                    taps_q <= taps_d;
                end
            end
        end else begin : g_systolic
            // Systolic form: two sample registers and one partial sum per tap after the first.
            logic [2*N-3:0][DW-1:0]                 xd_d;
            logic [2*N-3:0][DW-1:0]                 xd_q;
            logic [N-2:0][fcfir_pkg::ACC_W-1:0]     p_d;
            logic [N-2:0][fcfir_pkg::ACC_W-1:0]     p_q;
            logic [N-1:0][fcfir_pkg::ACC_W-1:0]     mac;
            logic [fcfir_pkg::FILL_W-1:0]           fill_d;
            logic [fcfir_pkg::FILL_W-1:0]           fill_q;

            // Samples move two registers per tap and sums one, so each tap sees the
            // right sample; the fill count holds off valid until the first full sum.
            // A stage gives the result for a sample only once three later samples
            // have entered, so the last three samples of a burst wait for more input.
            // The count saturates, so after the first three samples every enable counts.
            always_comb begin
                mac[0] = fcfir_pkg::fcfir_mac('0, src_data[s], COEF[0]);
                for (int k = 1; k < N; k++) begin
                    mac[k] = fcfir_pkg::fcfir_mac(p_q[k-1], xd_q[2*k-1], COEF[k]);
                end
                xd_d        = xd_q;
                p_d         = p_q;
                fill_d      = fill_q;
                res_d       = res_q;
                res_d.valid = 1'b0;
                if (en) begin
                    xd_d[0] = src_data[s];
                    for (int i = 1; i < 2 * N - 2; i++) begin
                        xd_d[i] = xd_q[i-1];
                    end
                    p_d = mac[N-2:0];
                    if (fill_q != fcfir_pkg::FILL_MAX) begin
                        fill_d = fill_q + 1'b1;
                    end
                    res_d.data  = fcfir_pkg::fcfir_scale(mac[N-1]);
                    res_d.valid = (fill_q == fcfir_pkg::FILL_MAX);
                end
            end

            // Systolic registers.
            // Sums and samples clear to zero, which matches an empty history.
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    xd_q   <= '0;
                    p_q    <= '0;
                    fill_q <= fcfir_pkg::FILL_RST;
                end else if (clk_en) begin
                    xd_q   <= xd_d;
                    p_q    <= p_d;
                    fill_q <= fill_d;
                end
            end
        end

        // FIFO pointers and count; a write is refused only if the queue is full.
        // The write comes straight from the result register, one cycle after a take.
        // Ready drops when the count reaches the threshold, and the delay line and
        // the result register let only a few more samples in, far fewer than the
        // slots above the threshold, so the full refusal is a guard that never acts.
        // The read address is the next read pointer, so the head follows a pop at once.
        always_comb begin
            wr      = res_q.valid && (count_q != fcfir_pkg::FIFO_FULL);
            wptr_d  = wr ? wptr_q + 1'b1 : wptr_q;
            rptr_d  = fifo_pop[s] ? rptr_q + 1'b1 : rptr_q;
            rd_addr = rptr_d;
            count_d = count_q;
            if (wr && !fifo_pop[s]) begin
                count_d = count_q + 1'b1;
            end else if (!wr && fifo_pop[s]) begin
                count_d = count_q - 1'b1;
            end
        end

        // Ready is high below half occupancy and reaches the stage through a delay line.
        // The delay must be at least the stage latency; a longer one costs headroom.
        // All ready flops reset high, so a sample may be offered right after reset.
        always_comb begin
            rdy_d = {rdy_q[FD-2:0], (count_q < fcfir_pkg::HALF_THR)};
        end

        // The stage sees the oldest ready; the FIFO is valid while it holds an entry.
        assign stage_rdy[s]  = rdy_q[FD-1];
        assign fifo_valid[s] = (count_q != fcfir_pkg::COUNT_RST);

        // Stage result, FIFO state and ready delay registers.
        // Reset empties the FIFO and clears the result valid flag.
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                res_q   <= fcfir_pkg::BEAT_RST;
                rdy_q   <= '1;
                count_q <= fcfir_pkg::COUNT_RST;
                wptr_q  <= fcfir_pkg::PTR_RST;
                rptr_q  <= fcfir_pkg::PTR_RST;
            end else if (clk_en) begin
                res_q   <= res_d;
                rdy_q   <= rdy_d;
                count_q <= count_d;
                wptr_q  <= wptr_d;
                rptr_q  <= rptr_d;
            end
        end

        // Sample storage; the head word shows at the read register.
        // A word written into an empty FIFO passes through to the read register,
        // so it is at the head one cycle after the write.
        fcfir_fifo_mem #(
            .W  (DW),
            .AW (AW)
        ) u_mem (
            .clk     (clk),
            .reset_n (reset_n),
            .clk_en  (clk_en),
            .wr_en   (wr),
            .wr_addr (wptr_q),
            .wr_data (res_q.data),
            .rd_addr (rd_addr),
            .rd_data (fifo_head[s])
        );
    end

    // The chain's ready is the delayed ready of the first stage, taken from a flop.
    assign in_ready = stage_rdy[0];

    ////////////////////////////////////////////////////////////////////////////////
    // Two-entry output buffer, so a consumer stall never loses a word.
    fcfir_pkg::fcfir_beat_type ent0_d;
    fcfir_pkg::fcfir_beat_type ent0_q;
    fcfir_pkg::fcfir_beat_type ent1_d;
    fcfir_pkg::fcfir_beat_type ent1_q;
    logic                      buf_push;
    logic                      buf_pop;

    // The buffer takes a word while its second slot is free; the head drives the port.
    // A pop moves the second slot forward; a push fills the first free slot after it.
    // Readiness depends on the second slot only, so it comes from a register and
    // still leaves room for the word that is popped in the same cycle.
    always_comb begin
        buf_ready = ~ent1_q.valid;
        buf_push  = fifo_pop[S-1];
        buf_pop   = ent0_q.valid & out_ready;
        ent0_d    = ent0_q;
        ent1_d    = ent1_q;
        if (buf_pop) begin
            ent0_d       = ent1_q;
            ent1_d.valid = 1'b0;
        end
        if (buf_push) begin
            if (!ent0_d.valid) begin
                ent0_d.valid = 1'b1;
                ent0_d.data  = fifo_head[S-1];
            end else begin
                ent1_d.valid = 1'b1;
                ent1_d.data  = fifo_head[S-1];
            end
        end
    end

    // Buffer registers.
    // Both slots clear on reset, so output valid is low until the first result.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ent0_q <= fcfir_pkg::BEAT_RST;
            ent1_q <= fcfir_pkg::BEAT_RST;
        end else if (clk_en) begin
            ent0_q <= ent0_d;
            ent1_q <= ent1_d;
        end
    end

    // The port shows the head slot directly.
    assign out_valid = ent0_q.valid;
    assign out_data  = ent0_q.data;

endmodule

// ### rtl/fcfir_pkg.sv
// Constants, carrier types and helper functions for the flow-controlled FIR chain.
package fcfir_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths, depths and counts.
    localparam int DATA_W     = 16;
    localparam int COEF_W     = 16;
    localparam int ACC_W      = DATA_W + COEF_W + 2;
    localparam int NTAPS      = 4;
    localparam int COEF_FRAC  = 6;
    localparam int NSTAGES    = 3;
    localparam int FIFO_DEPTH = 64;
    localparam int FIFO_AW    = 6;
    localparam int FB_DELAY   = 4;
    localparam int FILL_W     = 2;

    // Occupancy at which a FIFO stops its stage, and the count values it is compared to.
    localparam logic [FIFO_AW:0]   HALF_THR   = 7'h20;
    localparam logic [FIFO_AW:0]   FIFO_FULL  = 7'h40;
    localparam logic [FIFO_AW:0]   COUNT_RST  = 7'h00;
    localparam logic [FIFO_AW-1:0] PTR_RST    = 6'h00;
    localparam logic [FILL_W-1:0]  FILL_MAX   = 2'h3;
    localparam logic [FILL_W-1:0]  FILL_RST   = 2'h0;

    // Default coefficients, unity gain at the chosen fraction width.
    localparam logic [NTAPS-1:0][COEF_W-1:0] COEF_DEF = {16'h0008, 16'h0018, 16'h0018, 16'h0008};

    ////////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } fcfir_beat_type;

    typedef enum logic [0:0] {
        FCFIR_DIRECT   = 1'b0,
        FCFIR_SYSTOLIC = 1'b1
    } fcfir_arch_type;

    localparam fcfir_beat_type BEAT_RST = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // Multiply one sample by one coefficient and add it to a running sum.
    function automatic logic signed [ACC_W-1:0] fcfir_mac(
        input logic signed [ACC_W-1:0] acc,
        input logic [DATA_W-1:0]       x,
        input logic [COEF_W-1:0]       c
    );
        logic signed [DATA_W+COEF_W-1:0] prod;
        prod = $signed(x) * $signed(c);
        return acc + ACC_W'(prod);
    endfunction

    // Bring a sum back to sample width by dropping the fraction bits.
    function automatic logic [DATA_W-1:0] fcfir_scale(input logic signed [ACC_W-1:0] acc);
        return acc[COEF_FRAC +: DATA_W];
    endfunction

endpackage

// ### rtl/fcfir_fifo_mem.sv
// Small dual-port sample memory with a registered, write-first read port.
`timescale 1ns/100ps
module fcfir_fifo_mem #(
    parameter int W  = 16,
    parameter int AW = 6
) (
    input  wire logic          clk,      // System clock.
    input  wire logic          reset_n,  // Asynchronous reset, active low.
    input  wire logic          clk_en,   // Freezes all state while low.
    input  wire logic          wr_en,    // Write strobe.
    input  wire logic [AW-1:0] wr_addr,  // Write address.
    input  wire logic [W-1:0]  wr_data,  // Write data.
    input  wire logic [AW-1:0] rd_addr,  // Read address, seen next cycle.
    output logic      [W-1:0]  rd_data   // Registered read data.
);

    logic [W-1:0] mem [2**AW];
    logic [W-1:0] rd_data_d;
    logic [W-1:0] rd_data_q;

    // A write to the address being read is passed through, so a word written into
    // an empty queue is at the head on the very next cycle.
    always_comb begin
        rd_data_d = mem[rd_addr];
        if (wr_en && (wr_addr == rd_addr)) begin
            rd_data_d = wr_data;
        end
    end

    // Storage array, written without reset.
    always_ff @(posedge clk) begin
        if (clk_en && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read register.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_q <= '0;
        end else if (clk_en) begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;

endmodule

// ### tb/fcfir_chain_sva.sv
// Port checker for the flow-controlled FIR chain.
`timescale 1ns/100ps
module fcfir_chain_sva (
    input wire logic                         clk,        // Clock.
    input wire logic                         reset_n,    // Reset, active low.
    input wire logic                         clk_en,     // Clock enable.
    input wire logic [fcfir_pkg::DATA_W-1:0] in_data,    // Source sample.
    input wire logic                         in_valid,   // Source valid.
    input wire logic                         in_ready,   // Chain ready.
    input wire logic [fcfir_pkg::DATA_W-1:0] out_data,   // Output sample.
    input wire logic                         out_valid,  // Output valid.
    input wire logic                         out_ready   // Consumer ready.
);
    logic [15:0] in_cnt_q;
    logic [15:0] in_cnt_d;
    logic [15:0] out_cnt_q;
    logic [15:0] out_cnt_d;
    logic [15:0] flight;

    ////////////////////////////////////////////////////////////////////////////
    // Counts accepted and delivered samples; their difference is what is inside.
    always_comb begin
        in_cnt_d  = in_cnt_q + 16'(clk_en && in_valid && in_ready);
        out_cnt_d = out_cnt_q + 16'(clk_en && out_valid && out_ready);
        flight    = in_cnt_q - out_cnt_q;
    end

    // Registers the counters.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            in_cnt_q  <= 16'h0000;
            out_cnt_q <= 16'h0000;
        end else begin
            in_cnt_q  <= in_cnt_d;
            out_cnt_q <= out_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // A sample entering an empty chain needs seven edges to come out.
    sequence first_take;
        in_cnt_q == 16'h0000 && in_valid && in_ready && clk_en;
    endsequence
    sequence quiet_then_out;
        ##1 (!out_valid)[*6] ##[1:200] out_valid;
    endsequence

    out_hold_a: assert property (out_valid && !(out_ready && clk_en) |=>
        out_valid && $stable(out_data)) else $error("output word changed before it was taken");
    freeze_a: assert property (!clk_en |=> $stable(in_ready) && $stable(out_valid) &&
        $stable(out_data)) else $error("state moved while the enable was low");
    first_latency_a: assert property (first_take |-> quiet_then_out)
        else $error("first output latency wrong");
    out_backed_a: assert property (out_valid |-> in_cnt_q > out_cnt_q)
        else $error("output valid without a sample inside");
    inflight_max_a: assert property (flight <= 16'd200)
        else $error("more samples inside than buffers hold");
    ready_cause_a: assert property (!in_ready |-> flight >= 16'd32)
        else $error("ready low below half occupancy");
    drain_bound_a: assert property (flight != 16'h0000 |-> ##[0:60] out_valid)
        else $error("samples stuck inside");
    last_take_a: assert property (out_valid && out_ready && clk_en && flight == 16'd1
        |=> !out_valid) else $error("valid stayed after the last word");
endmodule

bind fcfir_chain fcfir_chain_sva fcfir_chain_sva_i (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready)
);

// ### tb/fcfir_sink.sv
// Downstream consumer model that paces the ready flag of the chain.
`timescale 1ns/100ps
module fcfir_sink (
    input  wire logic       clk,        // System clock.
    input  wire logic [4:0] rate,       // Ready odds in sixteenths.
    output logic            out_ready   // Consumer accepts a sample.
);
    initial out_ready = 1'b0;

    // Ready is redrawn after each falling edge and held through the rising one.
    always @(negedge clk) begin
        out_ready <= ($urandom % 16) < rate;
    end
endmodule

// ### tb/tb_fcfir_chain.sv
// Self-checking bench for the flow-controlled FIR chain.
`timescale 1ns/100ps
`define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch %s expected %h seen %h", name, exp, got); end end
module tb_fcfir_chain;
    logic                         clk       = 1'b0;
    logic                         reset_n   = 1'b0;
    logic                         clk_en    = 1'b1;
    logic [fcfir_pkg::DATA_W-1:0] in_data   = 16'h0000;
    logic                         in_valid  = 1'b0;
    logic                         in_ready;
    logic [fcfir_pkg::DATA_W-1:0] out_data;
    logic                         out_valid;
    logic                         out_ready;
    logic [4:0]                   sink_rate = 5'h10;
    logic [fcfir_pkg::DATA_W-1:0] exp_v;
    logic [fcfir_pkg::DATA_W-1:0] exp_q[$];
    longint                       hist[3][4];
    int                           errors = 0;
    int                           check_count = 0;
    int                           cycle_cnt = 0;
    int                           lat;
    bit                           src_took;
    bit                           saw_low;

    always #5 clk = ~clk;

    fcfir_chain fcfir_chain_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
        .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
    fcfir_sink fcfir_sink_i (.clk(clk), .rate(sink_rate), .out_ready(out_ready));

    ////////////////////////////////////////////////////////////////////////////
    // Runs one accepted sample through three direct-form stages of the model.
    function automatic void model_push(logic [15:0] x);
        logic [15:0] v;
        longint      s;
        v = x;
        for (int st = 0; st < 3; st++) begin
            for (int t = 3; t > 0; t--) hist[st][t] = hist[st][t-1];
            hist[st][0] = longint'($signed(v));
            s = 0;
            for (int t = 0; t < 4; t++) begin
                s += hist[st][t] * longint'($signed(fcfir_pkg::COEF_DEF[t]));
            end
            v = 16'(s >>> 6);
        end
        exp_q.push_back(v);
    endfunction

    // Feeds the model with accepted samples and checks every delivered word.
    always @(posedge clk) begin
        src_took = reset_n && clk_en && in_valid && in_ready;
        if (src_took) model_push(in_data);
        if (!in_ready) saw_low = 1'b1;
        if (reset_n && clk_en && out_valid === 1'b1 && out_ready) begin
            `CHK("word_expected", 1'b1, exp_q.size() > 0)
            if (exp_q.size() > 0) begin
                exp_v = exp_q.pop_front();
                `CHK("out_data", exp_v, out_data)
            end
        end
    end

    // Cuts a hung run short.
    always @(posedge clk) begin
        cycle_cnt++;
        if (cycle_cnt == 20000) begin
            errors++;
            $display("mismatch run_done expected 1 seen 0");
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drives the source; a sample not yet taken is held unchanged.
    task automatic run_traffic(int n, int vrate, int erate);
        repeat (n) begin
            @(negedge clk);
            clk_en = ($urandom % 16) >= erate;
            if (!in_valid || src_took) begin
                in_valid = ($urandom % 16) < vrate;
                in_data  = 16'($urandom);
            end
        end
    endtask

    // Resets the chain and the model together.
    task automatic do_reset(int n);
        @(negedge clk);
        reset_n  = 1'b0;
        in_valid = 1'b0;
        clk_en   = 1'b1;
        hist     = '{default: 0};
        exp_q.delete();
        repeat (n) @(negedge clk);
        reset_n = 1'b1;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, impulse, full rate, stall and drain, random, reset again.
    initial begin
        void'($urandom(32'hf5597710));
        hist = '{default: 0};
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        `CHK("in_ready", 1'b1, in_ready)
        `CHK("out_valid", 1'b0, out_valid)
        `CHK("out_data", 16'h0000, out_data)
        in_valid = 1'b1;
        in_data  = 16'h0100;
        @(negedge clk);
        in_valid = 1'b0;
        lat = 1;
        while (out_valid !== 1'b1 && lat < 50) begin
            @(negedge clk);
            lat++;
        end
        `CHK("latency", 7, lat)
        run_traffic(300, 16, 0);
        sink_rate = 5'h00;
        saw_low = 1'b0;
        run_traffic(400, 16, 0);
        `CHK("ready_dropped", 1'b1, saw_low)
        `CHK("held_min", 1'b1, exp_q.size() >= 96)
        `CHK("held_max", 1'b1, exp_q.size() <= 3 * fcfir_pkg::FIFO_DEPTH + 8)
        sink_rate = 5'h10;
        run_traffic(400, 0, 0);
        `CHK("drained", 0, exp_q.size())
        `CHK("in_ready", 1'b1, in_ready)
        sink_rate = 5'h08;
        run_traffic(3000, 10, 3);
        do_reset(3);
        `CHK("out_valid", 1'b0, out_valid)
        `CHK("in_ready", 1'b1, in_ready)
        run_traffic(500, 12, 2);
        sink_rate = 5'h10;
        run_traffic(300, 0, 0);
        `CHK("drained", 0, exp_q.size())
        final_report();
    end
endmodule
